/* File: pdio_pkg.sv */
/*
  Package for the parallel digital I/O host register bank.
  Holds register offsets, the group 1 configuration field layout,
  reset values, timing constants and the carrier structs.
  Assumes a 40 MHz board clock and a 5-bit byte address inside the board.
*/
package pdio_pkg;

  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned SETTLE_STEP_NS = 100;
  localparam int unsigned SETTLE_STEP_CYC =
    (SETTLE_STEP_NS * 1000) / CLK_PERIOD_PS;

  localparam logic [4:0] OFF_GRP1_CFG = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h00;
  localparam logic [4:0] OFF_GRP2_CFG = 5'h02;
  localparam logic [4:0] OFF_THIRD_CFG = 5'h04;
  localparam logic [4:0] OFF_PORT_A = 5'h06;
  localparam logic [4:0] OFF_PORT_B = 5'h07;
  localparam logic [4:0] OFF_PORT_C = 5'h08;
  localparam logic [4:0] OFF_PORT_D = 5'h09;
  localparam logic [4:0] OFF_CNT_IRQ_CLR = 5'h0a;
  localparam logic [4:0] OFF_G1_TC_CLR = 5'h0c;
  localparam logic [4:0] OFF_G2_TC_CLR = 5'h0e;
  localparam logic [4:0] OFF_TRIG_SHIFT = 5'h10;
  localparam logic [4:0] OFF_TRIG_STROBE = 5'h12;
  localparam logic [4:0] OFF_FOURTH_CFG = 5'h14;
  localparam logic [4:0] OFF_TIMER_ONE = 5'h18;
  localparam logic [4:0] OFF_TIMER_TWO = 5'h1a;
  localparam logic [4:0] OFF_TIMER_THREE = 5'h1c;
  localparam logic [4:0] OFF_TIMER_CMD = 5'h1e;

  localparam int unsigned GROUP1_CONFIG_DMA_EN_BIT = 15;
  localparam int unsigned GROUP1_CONFIG_IRQ_EN_BIT = 14;
  localparam int unsigned GROUP1_CONFIG_DELAY_HI = 13;
  localparam int unsigned GROUP1_CONFIG_DELAY_LO = 11;
  localparam int unsigned GROUP1_CONFIG_LRESET_BIT = 8;
  localparam int unsigned GROUP1_CONFIG_REQ_INV_BIT = 6;
  localparam int unsigned GROUP1_CONFIG_PULSE_BIT = 4;

  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [6:0] STATUS_PAD = 7'h00;

  typedef enum logic [1:0] {
    PDIO_IDLE = 2'b00,
    PDIO_READY = 2'b01,
    PDIO_SETTLE = 2'b11,
    PDIO_ACK = 2'b10
  } pdio_hs_t;

  typedef struct packed {
    logic [15:0] g1_cfg;
    logic [15:0] g2_cfg;
    logic [15:0] third_cfg;
    logic [15:0] fourth_cfg;
  } pdio_cfg_t;

  typedef struct packed {
    logic [7:0] port_a;
    logic [7:0] port_b;
    logic [7:0] port_c;
    logic [7:0] port_d;
  } pdio_ports_t;

  typedef struct packed {
    logic [7:0] tmr1;
    logic [7:0] tmr2;
    logic [7:0] tmr3;
    logic [7:0] tmr_cmd;
    logic [7:0] trig_shift;
  } pdio_misc_t;

  typedef struct packed {
    pdio_cfg_t cfg;
    pdio_ports_t ports;
    pdio_misc_t misc;
    logic cnt_irq;
    logic g1_tc_irq;
    logic g2_tc_irq;
    logic lreset_seen;
    pdio_hs_t hs;
    logic [7:0] delay_cnt;
    logic [1:0] req_sync;
    logic req_prev;
    logic g1_data_ready;
    logic trig_strobe;
    logic [15:0] rd_data;
  } pdio_state_t;

endpackage : pdio_pkg

/* File: pdio_regs.sv */
/*
  Host register bank of the parallel digital I/O board, with a simple
  group 1 handshake engine that exercises the configuration word.
  Assumes an I/O-channel style host giving a full 10-bit I/O address,
  a one-cycle read or write strobe and a byte/word size flag.
*/
`timescale 1ns/100ps
module pdio_regs
  import pdio_pkg::*;
#(
  parameter logic [9:0] BASE_ADDR = 10'h240
) (
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  input wire logic CLK_EN_IN,
  input wire logic [9:0] ADDR_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic WORD_IN,
  input wire logic [15:0] WDATA_IN,
  output logic [15:0] RDATA_OUT,
  input wire logic GRP1_REQUEST_IN,
  input wire logic CNT_EVENT_IN,
  input wire logic G1_TC_IN,
  input wire logic G2_TC_IN,
  output logic GRP1_ACK_OUT,
  output logic GRP1_DMA_REQ_OUT,
  output logic GRP1_IRQ_OUT,
  output logic [31:0] PORT_DATA_OUT,
  output logic [15:0] GRP2_CFG_OUT,
  output logic [15:0] THIRD_CFG_OUT,
  output logic [15:0] FOURTH_CFG_OUT,
  output logic [31:0] TIMER_DATA_OUT,
  output logic [7:0] TRIG_SHIFT_OUT,
  output logic TRIG_STROBE_OUT
);

  pdio_state_t s_q, s_d;
  logic hit;
  logic [4:0] off;
  logic req_act;
  logic req_evt;
  logic [7:0] delay_len;
  logic [15:0] wr_cfg;

  // The board claims a 32-byte window above the base address.
  assign hit = (ADDR_IN[9:5] == BASE_ADDR[9:5]);
  assign off = ADDR_IN[4:0];

  // Request level after polarity; low-active when the invert bit is set.
  assign req_act = s_q.req_sync[1] ^ s_q.cfg.g1_cfg[GROUP1_CONFIG_REQ_INV_BIT];
  // Pulse mode acts on the leading edge, level mode on the level.
  assign req_evt = s_q.cfg.g1_cfg[GROUP1_CONFIG_PULSE_BIT] ?
                   (req_act & ~s_q.req_prev) : req_act;
  // Delay code times one 100 ns step; code 0 still gives one clock of settle before ack.
  assign delay_len = 8'((32'(s_q.cfg.g1_cfg[GROUP1_CONFIG_DELAY_HI:GROUP1_CONFIG_DELAY_LO]) *
                     SETTLE_STEP_CYC));

  always_comb begin
    s_d = s_q;
    wr_cfg = WDATA_IN;
    s_d.trig_strobe = 1'b0;
    s_d.req_sync = {s_q.req_sync[0], GRP1_REQUEST_IN};
    s_d.req_prev = req_act;
    if (CNT_EVENT_IN) begin
      s_d.cnt_irq = 1'b1;
    end
    if (G1_TC_IN) begin
      s_d.g1_tc_irq = 1'b1;
    end
    if (G2_TC_IN) begin
      s_d.g2_tc_irq = 1'b1;
    end
    case (s_q.hs)
      PDIO_IDLE: begin
        if (req_evt) begin
          s_d.hs = PDIO_READY;
          s_d.g1_data_ready = 1'b1;
        end
      end
      PDIO_READY: begin
        if (!s_q.g1_data_ready) begin
          s_d.hs = PDIO_SETTLE;
          s_d.delay_cnt = delay_len;
        end
      end
      PDIO_SETTLE: begin
        if (s_q.delay_cnt == 8'h00) begin
          s_d.hs = PDIO_ACK;
        end else begin
          s_d.delay_cnt = s_q.delay_cnt - 8'h01;
        end
      end
      PDIO_ACK: begin
        if (s_q.cfg.g1_cfg[GROUP1_CONFIG_PULSE_BIT] || !req_act) begin
          s_d.hs = PDIO_IDLE;
        end
      end
      default: begin
        s_d.hs = PDIO_IDLE;
      end
    endcase
    // Byte writes carry no upper half; word writes to byte registers
    // simply drop it, except at ports A and C, which pass it on to ports B and D.
    if (!WORD_IN) begin
      wr_cfg = {8'h00, WDATA_IN[7:0]};
    end
    if (hit && WR_IN) begin
      case (off)
        OFF_GRP1_CFG: begin
          s_d.cfg.g1_cfg = wr_cfg;
          if (wr_cfg[GROUP1_CONFIG_LRESET_BIT]) begin
            s_d.lreset_seen = 1'b1;
          end else if (s_q.lreset_seen) begin
            // Only the falling write resets, so a held bit cannot
            // wedge the engine mid-transfer.
            s_d.lreset_seen = 1'b0;
            s_d.hs = PDIO_IDLE;
            s_d.g1_data_ready = 1'b0;
            s_d.delay_cnt = 8'h00;
          end
        end
        OFF_GRP2_CFG: s_d.cfg.g2_cfg = wr_cfg;
        OFF_THIRD_CFG: s_d.cfg.third_cfg = wr_cfg;
        OFF_FOURTH_CFG: s_d.cfg.fourth_cfg = wr_cfg;
        OFF_PORT_A: begin
          s_d.ports.port_a = WDATA_IN[7:0];
          if (WORD_IN) begin
            s_d.ports.port_b = WDATA_IN[15:8];
          end
          s_d.g1_data_ready = 1'b0;
        end
        OFF_PORT_B: s_d.ports.port_b = WDATA_IN[7:0];
        OFF_PORT_C: begin
          s_d.ports.port_c = WDATA_IN[7:0];
          if (WORD_IN) begin
            s_d.ports.port_d = WDATA_IN[15:8];
          end
        end
        OFF_PORT_D: s_d.ports.port_d = WDATA_IN[7:0];
        // A clear write loses to an event in the same cycle.
        OFF_CNT_IRQ_CLR: s_d.cnt_irq = CNT_EVENT_IN;
        OFF_G1_TC_CLR: s_d.g1_tc_irq = G1_TC_IN;
        OFF_G2_TC_CLR: s_d.g2_tc_irq = G2_TC_IN;
        OFF_TRIG_SHIFT: s_d.misc.trig_shift = WDATA_IN[7:0];
        OFF_TRIG_STROBE: s_d.trig_strobe = 1'b1;
        OFF_TIMER_ONE: s_d.misc.tmr1 = WDATA_IN[7:0];
        OFF_TIMER_TWO: s_d.misc.tmr2 = WDATA_IN[7:0];
        OFF_TIMER_THREE: s_d.misc.tmr3 = WDATA_IN[7:0];
        OFF_TIMER_CMD: s_d.misc.tmr_cmd = WDATA_IN[7:0];
        default: begin
          // Unmapped offsets are ignored.
        end
      endcase
    end
    if (hit && RD_IN) begin
      case (off)
        // Direction alone picks status over config at offset 00.
        OFF_STATUS: s_d.rd_data = {STATUS_PAD, s_q.hs, s_q.req_sync[1],
          GRP1_IRQ_OUT, GRP1_DMA_REQ_OUT, s_q.g1_data_ready,
          s_q.cnt_irq, s_q.g1_tc_irq, s_q.g2_tc_irq};
        OFF_PORT_A: begin
          s_d.rd_data = {s_q.ports.port_b, s_q.ports.port_a};
          s_d.g1_data_ready = 1'b0;
        end
        OFF_PORT_B: s_d.rd_data = {8'h00, s_q.ports.port_b};
        OFF_PORT_C: s_d.rd_data = {s_q.ports.port_d, s_q.ports.port_c};
        OFF_PORT_D: s_d.rd_data = {8'h00, s_q.ports.port_d};
        OFF_TIMER_ONE: s_d.rd_data = {8'h00, s_q.misc.tmr1};
        OFF_TIMER_TWO: s_d.rd_data = {8'h00, s_q.misc.tmr2};
        OFF_TIMER_THREE: s_d.rd_data = {8'h00, s_q.misc.tmr3};
        default: s_d.rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      s_q <= '0;
      s_q.cfg <= {4{CFG_RESET}};
      s_q.ports <= {4{BYTE_RESET}};
      s_q.hs <= PDIO_IDLE;
    end else if (CLK_EN_IN) begin
      s_q <= s_d;
    end
  end

  // Requests follow the ready flag only while enabled.
  assign GRP1_DMA_REQ_OUT = s_q.g1_data_ready &
                            s_q.cfg.g1_cfg[GROUP1_CONFIG_DMA_EN_BIT];
  assign GRP1_IRQ_OUT = s_q.g1_data_ready &
                        s_q.cfg.g1_cfg[GROUP1_CONFIG_IRQ_EN_BIT];
  assign GRP1_ACK_OUT = (s_q.hs == PDIO_ACK);
  assign RDATA_OUT = s_q.rd_data;
  assign PORT_DATA_OUT = s_q.ports;
  assign GRP2_CFG_OUT = s_q.cfg.g2_cfg;
  assign THIRD_CFG_OUT = s_q.cfg.third_cfg;
  assign FOURTH_CFG_OUT = s_q.cfg.fourth_cfg;
  assign TIMER_DATA_OUT = {s_q.misc.tmr1, s_q.misc.tmr2, s_q.misc.tmr3,
                           s_q.misc.tmr_cmd};
  assign TRIG_SHIFT_OUT = s_q.misc.trig_shift;
  assign TRIG_STROBE_OUT = s_q.trig_strobe;

endmodule : pdio_regs

/* File: pdio_regs_sva.sv */
/* Port assertions for the host register bank.
   Bound to every pdio_regs instance; sees its ports only. */
`timescale 1ns/100ps
module pdio_regs_sva
  import pdio_pkg::*;
#(
  parameter logic [9:0] BASE_ADDR = 10'h240
) (
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  input wire logic CLK_EN_IN,
  input wire logic [9:0] ADDR_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic WORD_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic [15:0] RDATA_OUT,
  input wire logic GRP1_DMA_REQ_OUT,
  input wire logic GRP1_IRQ_OUT,
  input wire logic [31:0] PORT_DATA_OUT,
  input wire logic [15:0] GRP2_CFG_OUT,
  input wire logic [31:0] TIMER_DATA_OUT,
  input wire logic [7:0] TRIG_SHIFT_OUT,
  input wire logic TRIG_STROBE_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);
  wire logic hit = CLK_EN_IN && ADDR_IN[9:5] == BASE_ADDR[9:5];
  wire logic [4:0] off = ADDR_IN[4:0];
  wire logic [7:0] wlo = WDATA_IN[7:0];
  wire logic [7:0] whi = WDATA_IN[15:8];
  wire logic strb_wr = WR_IN && hit && off == 5'h12;
  sequence wr_s(logic [4:0] o, logic w);
    WR_IN && hit && off == o && WORD_IN == w;
  endsequence
  sequence rd_s(logic [4:0] o);
    RD_IN && hit && off == o && WORD_IN;
  endsequence
  port_word_a: assert property (wr_s(5'h06, 1'b1) |=>
    PORT_DATA_OUT[31:16] == {$past(wlo), $past(whi)}) else $error("port pair");
  group2_config_load_a: assert property (wr_s(5'h02, 1'b1) |=>
    GRP2_CFG_OUT == $past(WDATA_IN)) else $error("group2_config load");
  shift_low_a: assert property (wr_s(5'h10, 1'b0) |=>
    TRIG_SHIFT_OUT == $past(wlo)) else $error("shift byte");
  strobe_pulse_a: assert property (strb_wr |=>
    TRIG_STROBE_OUT ##1 !TRIG_STROBE_OUT) else $error("strobe pulse");
  strobe_cause_a: assert property ($rose(TRIG_STROBE_OUT) |->
    $past(strb_wr)) else $error("stray strobe");
  status_req_a: assert property (rd_s(5'h00) |=> RDATA_OUT[5:4] ==
    {$past(GRP1_IRQ_OUT), $past(GRP1_DMA_REQ_OUT)}) else $error("status");
  wo_read_a: assert property (rd_s(5'h02) |=>
    RDATA_OUT == 16'h0000) else $error("write-only read");
  byte_upper_a: assert property (rd_s(5'h07) |=>
    RDATA_OUT[15:8] == 8'h00) else $error("byte upper");
  timer_cmd_a: assert property (wr_s(5'h1e, 1'b1) |=>
    TIMER_DATA_OUT[7:0] == $past(wlo)) else $error("timer command");
  miss_ignore_a: assert property (WR_IN && !hit |=>
    $stable(GRP2_CFG_OUT)) else $error("miss write");
endmodule : pdio_regs_sva
bind pdio_regs pdio_regs_sva #(.BASE_ADDR(BASE_ADDR)) sva_u (.*);

/* File: pdio_host.sv */
/* Host bus model doing one byte or word access at a time.
   Assumes the bank samples strobes on the rising clock edge. */
`timescale 1ns/100ps
module pdio_host (
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  output logic [9:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic word_out,
  output logic [15:0] wdata_out
);
  initial begin
    addr_out = 10'h000;
    wr_out = 1'b0;
    rd_out = 1'b0;
    word_out = 1'b0;
    wdata_out = 16'h0000;
  end
  // Callers read status wordwise and write the shift byte bytewise.
  task automatic acc(input logic w, input logic wd, input logic [9:0] a,
    input logic [15:0] d, output logic [15:0] q);
    addr_out <= a;
    wr_out <= w;
    rd_out <= !w;
    word_out <= wd;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    // A released data bus must not keep showing the last value.
    wdata_out <= ~d;
    @(posedge clk_in);
    q = rdata_in;
  endtask : acc
endmodule : pdio_host

/* File: tb_top.sv */
/* Self-checking bench for the register bank.
   Host side through pdio_host; request and event pins driven here. */
`timescale 1ns/100ps
module tb_top;
  import pdio_pkg::*;
  localparam logic [9:0] B = 10'h240;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [9:0] a;
  logic wr, rd, wd, ack, dma, irq, stb;
  logic [15:0] wdat, rdat, q, v, c2, c3, c4, n;
  logic [31:0] ports, tmr;
  logic [7:0] sh;
  logic [2:0] e;
  logic [31:0] lfsr_q = 32'h000179e6;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  pdio_regs #(.BASE_ADDR(B)) dut_u (.CLK_SYS_IN(clk), .RESETN_IN(rst_n),
    .CLK_EN_IN(1'b1), .ADDR_IN(a), .WR_IN(wr), .RD_IN(rd), .WORD_IN(wd),
    .WDATA_IN(wdat), .RDATA_OUT(rdat), .GRP1_REQUEST_IN(req),
    .CNT_EVENT_IN(ev[2]), .G1_TC_IN(ev[1]), .G2_TC_IN(ev[0]),
    .GRP1_ACK_OUT(ack), .GRP1_DMA_REQ_OUT(dma), .GRP1_IRQ_OUT(irq),
    .PORT_DATA_OUT(ports), .GRP2_CFG_OUT(c2), .THIRD_CFG_OUT(c3),
    .FOURTH_CFG_OUT(c4), .TIMER_DATA_OUT(tmr), .TRIG_SHIFT_OUT(sh),
    .TRIG_STROBE_OUT(stb));
  pdio_host host_u (.clk_in(clk), .rdata_in(rdat), .addr_out(a),
    .wr_out(wr), .rd_out(rd), .word_out(wd), .wdata_out(wdat));
  initial begin
    forever #12.5 clk = ~clk;
  end
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q[15:0];
  endfunction : rnd
  function automatic logic [15:0] port_pair(input logic [15:0] d);
    return {d[7:0], d[15:8]};
  endfunction : port_pair
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      host_u.acc(1'b1, 1'b1, B + 10'h06, v, q);
      chk(ports[31:16], port_pair(v));
      host_u.acc(1'b0, 1'b1, B + 10'h06, 16'h0000, q);
      chk(q, v);
      host_u.acc(1'b1, 1'b1, B + 10'h02, v, q);
      host_u.acc(1'b1, 1'b1, B + 10'h04, ~v, q);
      host_u.acc(1'b1, 1'b1, B + 10'h14, v ^ 16'h5a5a, q);
      chk(c2, v);
      chk(c3 ^ c4, ~v ^ v ^ 16'h5a5a);
      host_u.acc(1'b1, 1'b0, B + 10'h10, v, q);
      chk({8'h00, sh}, {8'h00, v[7:0]});
      host_u.acc(1'b1, 1'b1, B + 10'h1e, v, q);
      chk({8'h00, tmr[7:0]}, {8'h00, v[7:0]});
    end
    host_u.acc(1'b1, 1'b1, B + 10'h22, ~v, q);
    chk(c2, v);
    host_u.acc(1'b0, 1'b1, B + 10'h02, 16'h0000, q);
    chk(q, 16'h0000);
    host_u.acc(1'b0, 1'b1, B + 10'h07, 16'h0000, q);
    chk(q, {8'h00, v[15:8]});
    host_u.acc(1'b1, 1'b0, B + 10'h12, 16'h00ff, q);
    for (int i = 0; i < 3; i++) begin
      e = 3'h1 << i;
      ev <= e;
      @(posedge clk);
      ev <= 3'h0;
      host_u.acc(1'b0, 1'b1, B, 16'h0000, q);
      chk({13'h0000, q[2:0]}, {13'h0000, e});
      host_u.acc(1'b1, 1'b1, B + 10'h0e - 10'(2 * i), 16'hffff, q);
      host_u.acc(1'b0, 1'b1, B, 16'h0000, q);
      chk({13'h0000, q[2:0]}, 16'h0000);
    end
    host_u.acc(1'b1, 1'b1, B, 16'hc000, q);
    req <= 1'b1;
    repeat (4) @(posedge clk);
    chk({14'h0000, dma, irq}, 16'h0003);
    host_u.acc(1'b0, 1'b1, B, 16'h0000, q);
    chk({13'h0000, q[5:3]}, 16'h0007);
    req <= 1'b0;
    host_u.acc(1'b1, 1'b1, B, 16'h1800, q);
    req <= 1'b1;
    repeat (4) @(posedge clk);
    host_u.acc(1'b0, 1'b0, B + 10'h06, 16'h0000, q);
    n = 16'h0000;
    // The wait is bounded so a stuck delay counter cannot hang the run.
    // Sampled between edges so the acknowledge is settled when looked at.
    while (ack !== 1'b1 && n < 16'h0064) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0000, n >= 16'(3 * SETTLE_STEP_CYC) &&
      n <= 16'(3 * SETTLE_STEP_CYC + 3)}, 16'h0001);
    host_u.acc(1'b1, 1'b1, B, 16'h0100, q);
    req <= 1'b0;
    host_u.acc(1'b1, 1'b1, B, 16'h4040, q);
    repeat (5) @(posedge clk);
    chk({15'h0000, irq}, 16'h0001);
    // Pulse mode: a request held high must not rearm the ready flag.
    host_u.acc(1'b1, 1'b1, B, 16'h4010, q);
    host_u.acc(1'b0, 1'b0, B + 10'h06, 16'h0000, q);
    repeat (5) @(posedge clk);
    req <= 1'b1;
    repeat (5) @(posedge clk);
    chk({15'h0000, irq}, 16'h0001);
    host_u.acc(1'b0, 1'b0, B + 10'h06, 16'h0000, q);
    repeat (10) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    close_out();
  end
endmodule : tb_top
